/* File: rtl/airs_pkg.sv */
// Function
// - Codes 0-15 route external channels in order
// - Codes 16-19 pick temp, regulator, supply, ground
// - Codes 20-31 connect no positive source
// - Bit 7 picks 1.65 V or 2.4 V
// - Bit 5 picks ground or analog ground
// - Bits 4:3 choose converter reference source
// - Bit 2 powers the temperature sensor
package airs_pkg;

	// ****************************************
	// Register map
	// ****************************************
	localparam logic [7:0] REF_CTRL_ADDR   = 8'hD1;  // Reference control offset
	localparam logic [7:0] POS_SEL_ADDR    = 8'hBB;  // Positive input select offset
	localparam logic [7:0] REF_CTRL_RESET  = 8'h18;  // Reference control reset
	localparam logic [7:0] POS_SEL_RESET   = 8'h1F;  // Input select reset, nothing connected
	localparam logic [7:0] POS_SEL_WMASK   = 8'h1F;  // Writable input select bits
	localparam logic [7:0] REF_CTRL_WMASK  = 8'hBC;  // Writable reference control bits

	// ****************************************
	// Field positions
	// ****************************************
	localparam int unsigned SEL_HI         = 4;      // Selection field top bit
	localparam int unsigned LVL_BIT        = 7;      // Internal reference level
	localparam int unsigned GND_BIT        = 5;      // Ground reference select
	localparam int unsigned VSEL_HI        = 4;      // Reference select top
	localparam int unsigned VSEL_LO        = 3;      // Reference select bottom
	localparam int unsigned TEMP_BIT       = 2;      // Temperature sensor enable

	// ****************************************
	// Codes
	// ****************************************
	localparam logic [4:0] SEL_EXT_LAST    = 5'h0F;  // Last external channel
	localparam logic [4:0] SEL_TEMP        = 5'h10;  // Temperature sensor
	localparam logic [4:0] SEL_LDO         = 5'h11;  // Regulator output
	localparam logic [4:0] SEL_SUPPLY      = 5'h12;  // Supply rail
	localparam logic [4:0] SEL_GROUND      = 5'h13;  // Ground

	typedef enum logic [1:0] {
		AIRS_REF_PIN      = 2'h0,                    // External reference pin
		AIRS_REF_SUPPLY   = 2'h1,                    // Supply pin
		AIRS_REF_DIGITAL  = 2'h2,                    // Internal 1.8 V digital supply
		AIRS_REF_INTERNAL = 2'h3                     // Internal reference
	} airs_vref_t;

	// Internal source one-hot selects
	typedef struct packed {
		logic temp;                                  // Temperature sensor
		logic ldo;                                   // Regulator output
		logic supply;                                // Supply rail
		logic ground;                                // Ground
	} airs_int_src_t;

	// Reference steering outputs
	typedef struct packed {
		logic [3:0] vref_onehot;                     // One-hot reference source
		logic       level_high;                      // 2.4 V when set, 1.65 V when clear
		logic       analog_ground;                   // Analog ground pin when set
		logic       temp_power;                      // Sensor powered
	} airs_ref_out_t;

endpackage : airs_pkg

/* File: rtl/airs_top.sv */
`timescale 1ns/1ps
module airs_top (
	input  wire logic                   clk,
	input  wire logic                   rst_b,
	input  wire logic [7:0]             sfr_addr,
	input  wire logic                   sfr_wr,
	input  wire logic [7:0]             sfr_wdata,
	input  wire logic                   sfr_rd,
	output logic      [7:0]             sfr_rdata,
	output logic      [15:0]            ext_chan_onehot,
	output airs_pkg::airs_int_src_t     int_src,
	output logic                        pos_connected,
	output airs_pkg::airs_ref_out_t     ref_out
);

	// ****************************************
	// Registers
	// ****************************************
	logic [7:0] positive_input_select;   // Input select register
	logic [7:0] reference_control;       // Reference control register

	// ****************************************
	// Decode, continuous
	// ****************************************
	wire        hit_sel  = (sfr_addr == airs_pkg::POS_SEL_ADDR);   // Select register hit
	wire        hit_ref  = (sfr_addr == airs_pkg::REF_CTRL_ADDR);  // Reference register hit
	// Reserved bits are held in hardware, so a careless write cannot disturb them
	wire [7:0]  next_sel = (sfr_wdata & airs_pkg::POS_SEL_WMASK) |
	                       (airs_pkg::POS_SEL_RESET & ~airs_pkg::POS_SEL_WMASK);
	wire [7:0]  next_ref = (sfr_wdata & airs_pkg::REF_CTRL_WMASK) |
	                       (airs_pkg::REF_CTRL_RESET & ~airs_pkg::REF_CTRL_WMASK);
	wire [4:0]  sel_code = positive_input_select[airs_pkg::SEL_HI:0];
	wire        is_ext   = (sel_code <= airs_pkg::SEL_EXT_LAST);
	wire [15:0] next_ext = is_ext ? (16'h0001 << sel_code[3:0]) : 16'h0000;
	wire airs_pkg::airs_int_src_t next_int = '{
		temp:   (sel_code == airs_pkg::SEL_TEMP),
		ldo:    (sel_code == airs_pkg::SEL_LDO),
		supply: (sel_code == airs_pkg::SEL_SUPPLY),
		ground: (sel_code == airs_pkg::SEL_GROUND)};
	// Reserved codes leave every select low
	wire        next_conn = is_ext | (|next_int);
	wire [1:0]  vsel      = reference_control[airs_pkg::VSEL_HI:airs_pkg::VSEL_LO];
	wire airs_pkg::airs_ref_out_t next_refo = '{
		vref_onehot:   (4'h1 << vsel),
		level_high:    reference_control[airs_pkg::LVL_BIT],
		analog_ground: reference_control[airs_pkg::GND_BIT],
		temp_power:    reference_control[airs_pkg::TEMP_BIT]};
	wire [7:0]  next_rdata = hit_sel ? positive_input_select :
	                         hit_ref ? reference_control : 8'h00;

	// ****************************************
	// Register writes
	// ****************************************
	// Reset value keeps the internal reference selected
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			positive_input_select <= airs_pkg::POS_SEL_RESET;
			reference_control     <= airs_pkg::REF_CTRL_RESET;
		end else if (sfr_wr) begin
			if (hit_sel) begin
				positive_input_select <= next_sel;
			end
			if (hit_ref) begin
				reference_control <= next_ref;
			end
		end
	end

	// ****************************************
	// Output flops
	// ****************************************
	// Outputs lag the register by one cycle, a static front end does not mind
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			sfr_rdata       <= 8'h00;
			ext_chan_onehot <= 16'h0000;
			int_src         <= '0;
			pos_connected   <= 1'b0;
			ref_out         <= '{vref_onehot: 4'h8, default: 1'b0};
		end else begin
			sfr_rdata       <= sfr_rd ? next_rdata : 8'h00;
			ext_chan_onehot <= next_ext;
			int_src         <= next_int;
			pos_connected   <= next_conn;
			ref_out         <= next_refo;
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	a_ext_route: assert property (@(posedge clk) disable iff (!rst_b)
		$past(rst_b) && ($past(sel_code) <= 5'h0F) |->
		ext_chan_onehot == (16'h0001 << $past(sel_code[3:0])))
		else $error("external channel route wrong");
	a_temp_route: assert property (@(posedge clk) disable iff (!rst_b)
		$past(rst_b) |-> int_src.temp == ($past(sel_code) == 5'h10))
		else $error("temperature source route wrong");
	a_gnd_route: assert property (@(posedge clk) disable iff (!rst_b)
		$past(rst_b) |-> int_src.ground == ($past(sel_code) == 5'h13))
		else $error("ground source route wrong");
	a_reserved_none: assert property (@(posedge clk) disable iff (!rst_b)
		$past(rst_b) && ($past(sel_code) >= 5'h14) |->
		!pos_connected && ext_chan_onehot == 16'h0000 && int_src == '0)
		else $error("reserved code connected a source");
	a_reserved_hold: assert property (@(posedge clk) disable iff (!rst_b)
		reference_control[6] == 1'b0 && reference_control[1:0] == 2'h0 &&
		positive_input_select[7:5] == 3'h0)
		else $error("reserved bits changed");
	a_level_bit: assert property (@(posedge clk) disable iff (!rst_b)
		sfr_wr && hit_ref ##2 1'b1 |-> ref_out.level_high == $past(sfr_wdata[7], 2))
		else $error("reference level not applied");
	a_ground_bit: assert property (@(posedge clk) disable iff (!rst_b)
		sfr_wr && hit_ref ##2 1'b1 |-> ref_out.analog_ground == $past(sfr_wdata[5], 2))
		else $error("ground select not applied");
	a_vref_sel: assert property (@(posedge clk) disable iff (!rst_b)
		$past(rst_b) |-> ref_out.vref_onehot == (4'h1 << $past(vsel)))
		else $error("reference source wrong");
	a_temp_power: assert property (@(posedge clk) disable iff (!rst_b)
		sfr_wr && hit_ref ##2 1'b1 |-> ref_out.temp_power == $past(sfr_wdata[2], 2))
		else $error("sensor power not applied");
	a_reset_val: assert property (@(posedge clk)
		!rst_b |=> reference_control == 8'h18)
		else $error("reference reset value wrong");

	// ****************************************
	// Assertions, source routing
	// ****************************************
	// Regulator select follows its code
	a_ldo_route: assert property (@(posedge clk) disable iff (!rst_b)
		$past(rst_b) |-> int_src.ldo == ($past(sel_code) == airs_pkg::SEL_LDO))
		else $error("regulator source route wrong");

	// Supply select follows its code
	a_supply_route: assert property (@(posedge clk) disable iff (!rst_b)
		$past(rst_b) |-> int_src.supply == ($past(sel_code) == airs_pkg::SEL_SUPPLY))
		else $error("supply source route wrong");

	// Internal codes leave every external channel open
	a_ext_none: assert property (@(posedge clk) disable iff (!rst_b)
		$past(rst_b) && ($past(sel_code) > airs_pkg::SEL_EXT_LAST) |->
		ext_chan_onehot == 16'h0000)
		else $error("external channel left connected");

	// Never two external channels at once
	a_ext_onehot: assert property (@(posedge clk) disable iff (!rst_b)
		$onehot0(ext_chan_onehot))
		else $error("external channels shorted");

	// Connected flag tracks the valid code range
	a_conn_flag: assert property (@(posedge clk) disable iff (!rst_b)
		$past(rst_b) |-> pos_connected == ($past(sel_code) <= airs_pkg::SEL_GROUND))
		else $error("connected flag wrong");

	// At most one source of any kind on the positive input
	a_source_single: assert property (@(posedge clk) disable iff (!rst_b)
		$onehot0({ext_chan_onehot, int_src}))
		else $error("positive input sources shorted");

	// ****************************************
	// Assertions, reference steering
	// ****************************************
	// Level output follows the register bit
	a_level_track: assert property (@(posedge clk) disable iff (!rst_b)
		$past(rst_b) |-> ref_out.level_high == $past(reference_control[airs_pkg::LVL_BIT]))
		else $error("reference level does not track");

	// Ground output follows the register bit
	a_ground_track: assert property (@(posedge clk) disable iff (!rst_b)
		$past(rst_b) |-> ref_out.analog_ground == $past(reference_control[airs_pkg::GND_BIT]))
		else $error("ground select does not track");

	// Sensor power follows the register bit
	a_temp_track: assert property (@(posedge clk) disable iff (!rst_b)
		$past(rst_b) |-> ref_out.temp_power == $past(reference_control[airs_pkg::TEMP_BIT]))
		else $error("sensor power does not track");

	// Exactly one reference source, a gap would float the converter
	a_vref_onehot: assert property (@(posedge clk) disable iff (!rst_b)
		$onehot(ref_out.vref_onehot))
		else $error("reference source not one-hot");

	// Reference select field takes the written value
	a_write_ref: assert property (@(posedge clk) disable iff (!rst_b)
		sfr_wr && hit_ref |=>
		reference_control[airs_pkg::VSEL_HI:airs_pkg::VSEL_LO] == $past(sfr_wdata[4:3]))
		else $error("reference select write lost");

	// ****************************************
	// Assertions, register access and reset
	// ****************************************
	// Selection field takes the written value
	a_write_sel: assert property (@(posedge clk) disable iff (!rst_b)
		sfr_wr && hit_sel |=> positive_input_select[4:0] == $past(sfr_wdata[4:0]))
		else $error("selection write lost");

	// Reserved select bits read back as zero
	a_read_sel: assert property (@(posedge clk) disable iff (!rst_b)
		sfr_rd && hit_sel |=> sfr_rdata[7:5] == 3'h0)
		else $error("reserved select bits read nonzero");

	// Reserved reference bits read back as zero
	a_read_ref: assert property (@(posedge clk) disable iff (!rst_b)
		sfr_rd && hit_ref |=> sfr_rdata[6] == 1'b0 && sfr_rdata[1:0] == 2'h0)
		else $error("reserved reference bits read nonzero");

	// Steering outputs come up on the internal reference
	a_ref_reset_out: assert property (@(posedge clk)
		!rst_b |=> ref_out == 7'h40)
		else $error("reference outputs reset wrong");

	// Selection comes up with nothing connected
	a_sel_reset: assert property (@(posedge clk)
		!rst_b |=> positive_input_select == airs_pkg::POS_SEL_RESET)
		else $error("selection reset value wrong");

endmodule : airs_top

/* File: tb/airs_analog_model.sv */
`timescale 1ns/1ps
// ****************************************
// Far side: analog mux and reference steering
// ****************************************
module airs_analog_model (
	input  wire logic [15:0]             ext_chan_onehot, // External channel selects
	input  wire airs_pkg::airs_int_src_t int_src,         // Internal source selects
	input  wire airs_pkg::airs_ref_out_t ref_out,         // Reference steering
	output logic      [4:0]              src_cnt,         // Sources on positive input
	output logic      [2:0]              vref_cnt         // Reference sources driven
);
	// Two sources at once would short them, so a count above one is a fault
	assign src_cnt  = 5'($countones(ext_chan_onehot)) + 5'($countones(int_src));
	assign vref_cnt = 3'($countones(ref_out.vref_onehot));
endmodule : airs_analog_model

/* File: tb/test_adc_input_reference_select.sv */
`timescale 1ns/1ps
module test_adc_input_reference_select;
	logic                    clk = 1'b0, rst_b = 1'b0, sfr_wr = 1'b0, sfr_rd = 1'b0;
	logic [7:0]              sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, d;
	logic [15:0]             ext_chan_onehot;   // Channel selects
	airs_pkg::airs_int_src_t int_src;           // Internal sources
	airs_pkg::airs_ref_out_t ref_out;           // Reference steering
	logic                    pos_connected;     // Any source on
	logic [4:0]              src_cnt;           // Model source count
	logic [2:0]              vref_cnt;          // Model reference count
	int                      err_total = 0, n_checks = 0, cyc = 0;
	localparam int           CEILING = 5000;    // Tests need well under a thousand cycles
	logic [7:0]              exp_ref;           // Expected reference control

	airs_top airs_top_i (
		.clk             (clk),
		.rst_b           (rst_b),
		.sfr_addr        (sfr_addr),
		.sfr_wr          (sfr_wr),
		.sfr_wdata       (sfr_wdata),
		.sfr_rd          (sfr_rd),
		.sfr_rdata       (sfr_rdata),
		.ext_chan_onehot (ext_chan_onehot),
		.int_src         (int_src),
		.pos_connected   (pos_connected),
		.ref_out         (ref_out)
	);

	airs_analog_model airs_analog_model_i (
		.ext_chan_onehot (ext_chan_onehot),
		.int_src         (int_src),
		.ref_out         (ref_out),
		.src_cnt         (src_cnt),
		.vref_cnt        (vref_cnt)
	);

	// 40 MHz clock
	always #12.5 clk = ~clk;

	// Compare, case equality so unknowns fail
	task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
		n_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] %0t %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask : check

	// One-cycle write strobe
	task automatic sfr_write(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk);
		sfr_addr  <= a;
		sfr_wdata <= v;
		sfr_wr    <= 1'b1;
		@(posedge clk);
		sfr_wr    <= 1'b0;
	endtask : sfr_write

	// Read data stands for the cycle after the strobe
	task automatic sfr_read(input logic [7:0] a, output logic [7:0] v);
		@(posedge clk);
		sfr_addr <= a;
		sfr_rd   <= 1'b1;
		@(posedge clk);
		sfr_rd   <= 1'b0;
		#1;
		v = sfr_rdata;
	endtask : sfr_read

	// Steering outputs lag a write by two edges
	task automatic settle;
		repeat (2) @(posedge clk);
		#1;
	endtask : settle

	task automatic stop_test;
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : stop_test

	// Timeout counts as a mismatch
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == CEILING) begin
			err_total++;
			stop_test();
		end
	end

	initial begin
		repeat (12) @(posedge clk);
		rst_b <= 1'b1;
		sfr_read(airs_pkg::REF_CTRL_ADDR, d);
		check(16'(d), 16'h0018, "reference reset");
		sfr_read(airs_pkg::POS_SEL_ADDR, d);
		check(16'(d), 16'h001F, "select reset");
		check(16'(ref_out), 16'h0040, "steering reset");
		check(16'(pos_connected), 16'h0000, "nothing connected");
		// Every selection code, reserved bits kept zero
		for (int c = 0; c < 32; c++) begin
			sfr_write(airs_pkg::POS_SEL_ADDR, 8'(c));
			settle();
			check(ext_chan_onehot, (c < 16) ? 16'(1 << c) : 16'h0000, "ext route");
			check(16'(int_src), {12'h000, c == 16, c == 17, c == 18, c == 19}, "int");
			check(16'(pos_connected), 16'(c < 20), "connected flag");
			check(16'(src_cnt), 16'(c < 20), "source count");
			sfr_read(airs_pkg::POS_SEL_ADDR, d);
			check(16'(d), 16'(c), "select readback");
		end
		// Every reference field combination
		for (int j = 0; j < 32; j++) begin
			exp_ref = {j[4], 1'b0, j[3], j[2:1], j[0], 2'b00};
			sfr_write(airs_pkg::REF_CTRL_ADDR, exp_ref);
			settle();
			check(16'(ref_out.level_high), 16'(j[4]), "level");
			check(16'(ref_out.analog_ground), 16'(j[3]), "ground");
			check(16'(ref_out.vref_onehot), 16'h0001 << j[2:1], "vref");
			check(16'(vref_cnt), 16'h0001, "one reference");
			check(16'(ref_out.temp_power), 16'(j[0]), "sensor power");
			sfr_read(airs_pkg::REF_CTRL_ADDR, d);
			check(16'(d), 16'(exp_ref), "reference readback");
		end
		// Read data drops back to zero after one cycle
		@(posedge clk);
		#1;
		check(16'(sfr_rdata), 16'h0000, "read data idle");
		// Unmapped address leaves the selection alone
		sfr_write(airs_pkg::POS_SEL_ADDR, 8'h03);
		sfr_write(8'hBC, 8'h05);
		settle();
		check(ext_chan_onehot, 16'h0008, "unmapped write");
		sfr_read(8'hBC, d);
		check(16'(d), 16'h0000, "unmapped read");
		// Reset in mid-run
		@(posedge clk);
		rst_b <= 1'b0;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		sfr_read(airs_pkg::REF_CTRL_ADDR, d);
		check(16'(d), 16'h0018, "reference reset again");
		check(ext_chan_onehot, 16'h0000, "ext after reset");
		check(16'(ref_out), 16'h0040, "steering after reset");
		stop_test();
	end
endmodule : test_adc_input_reference_select
